// File: src/alarm_seq_pkg.sv
// shared constants for the delayed-alarm sequencer
package alarm_seq_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TICK_PERIOD_S  = 1;
  localparam int unsigned TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned ACK_WINDOW_S   = 15;
  localparam int unsigned INVEST_LIMIT_S = 180;
  localparam int unsigned SEC_W          = 8;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACK    = 2'b01,
    ST_INVEST = 2'b10,
    ST_ALARM  = 2'b11
  } seq_state_type;
endpackage

// File: src/second_tick.sv
// divider giving a one-cycle pulse once per second
`timescale 1ns/1ps
module second_tick #(
  parameter int unsigned CYCLES = alarm_seq_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // restart the second from zero
  input  wire logic restart_i,
  // one-cycle tick
  output logic      tick_o
);
  import alarm_seq_pkg::*;

  initial begin
    if (CYCLES < 2) $error("second_tick: CYCLES must be at least 2");
  end

  localparam int unsigned CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] cnt_r;
  wire           wrap = (cnt_r == LAST);

  // ----------------------------------------
  // counter; restart keeps the first second whole
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= ZERO;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= (restart_i || wrap) ? ZERO : cnt_r + 1'b1;
      tick_o <= wrap && !restart_i;
    end
  end
endmodule

// File: src/positive_alarm_sequencer.sv
// delayed-alarm sequencer: acknowledge window, investigation phase, escalation
`timescale 1ns/1ps
// How it works
// - selected detector annunciates, opens acknowledge window
// - no acknowledge in window: alarm outputs
// - acknowledge starts investigation; reset cancels it
// - investigation expires unreset: alarm outputs
// - second selected detector in investigation: alarm
// - any other initiating device: immediate alarm
module positive_alarm_sequencer #(
  parameter int unsigned TICK_CYCLES = alarm_seq_pkg::TICK_CYCLES,
  parameter int unsigned ACK_S       = alarm_seq_pkg::ACK_WINDOW_S,
  parameter int unsigned INVEST_S    = alarm_seq_pkg::INVEST_LIMIT_S,
  parameter int unsigned N_DET       = 8
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // initiating devices
  input  wire logic [N_DET-1:0] sel_det_i,
  input  wire logic             other_init_i,
  // operator controls
  input  wire logic             ack_i,
  input  wire logic             sys_reset_i,
  // outputs
  output logic                  annunciate_o,
  output logic                  notify_o,
  output logic                  remote_o,
  output alarm_seq_pkg::seq_state_type state_o
);
  import alarm_seq_pkg::*;

  initial begin
    if (ACK_S < 1 || ACK_S > (2 ** SEC_W) - 1 || INVEST_S < 1 || INVEST_S > (2 ** SEC_W) - 1 || N_DET < 1)
      $error("positive_alarm_sequencer: unsupported parameter values");
  end

  localparam logic [SEC_W-1:0] ACK_LAST = SEC_W'(ACK_S);
  localparam logic [SEC_W-1:0] INV_LAST = SEC_W'(INVEST_S);
  localparam logic [SEC_W-1:0] SEC_ZERO = '0;

  seq_state_type    state_r;
  seq_state_type    state_nxt;
  logic [SEC_W-1:0] sec_r;
  logic [N_DET-1:0] first_r;
  logic             tick;

  // true on the tick that completes the last whole second of a window
  function automatic logic window_done(input logic [SEC_W-1:0] sec, input logic [SEC_W-1:0] last);
    window_done = (sec + 1'b1 >= last);
  endfunction

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  wire any_sel    = |sel_det_i;
  // a detector other than the one that opened the sequence
  wire second_sel = |(sel_det_i & ~first_r);
  wire ack_exp    = tick && window_done(sec_r, ACK_LAST);
  wire inv_exp    = tick && window_done(sec_r, INV_LAST);
  // seconds count only inside a timed window, so idle and alarm hold zero
  wire timing     = (state_r == ST_ACK) || (state_r == ST_INVEST);
  wire entering   = (state_nxt != state_r);

  second_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .restart_i  (entering),
    .tick_o     (tick)
  );

  // ----------------------------------------
  // next state; other devices win over everything
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (other_init_i) state_nxt = ST_ALARM;
        else if (any_sel) state_nxt = ST_ACK;
      end
      ST_ACK: begin
        if (other_init_i) state_nxt = ST_ALARM;
        else if (ack_i) state_nxt = ST_INVEST;
        else if (ack_exp) state_nxt = ST_ALARM;
      end
      ST_INVEST: begin
        if (other_init_i || second_sel) state_nxt = ST_ALARM;
        else if (sys_reset_i) state_nxt = ST_IDLE;
        else if (inv_exp) state_nxt = ST_ALARM;
      end
      ST_ALARM: begin
        // full alarm stays latched; reset here only without active inputs
        if (sys_reset_i && !other_init_i && !any_sel) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // state, seconds count and first detector
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      sec_r   <= SEC_ZERO;
      first_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (entering) sec_r <= SEC_ZERO;
      else if (tick && timing) sec_r <= sec_r + 1'b1;
      if (state_r == ST_IDLE) first_r <= sel_det_i;
    end
  end

  // ----------------------------------------
  // outputs registered from the next state
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      annunciate_o <= 1'b0;
      notify_o     <= 1'b0;
      remote_o     <= 1'b0;
    end else begin
      annunciate_o <= (state_nxt != ST_IDLE);
      notify_o     <= (state_nxt == ST_ALARM);
      remote_o     <= (state_nxt == ST_ALARM);
    end
  end

  assign state_o = state_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_ack_open;
    state_r == ST_IDLE && !other_init_i && any_sel;
  endsequence

  property p_open;
    @(posedge core_clk_i) disable iff (rst_i) s_ack_open |=> state_r == ST_ACK && annunciate_o;
  endproperty
  a_open: assert property (p_open) else $error("acknowledge window not opened");

  property p_ack_timeout;
    @(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_ACK && ack_exp && !ack_i) |=> notify_o && remote_o;
  endproperty
  a_ack_timeout: assert property (p_ack_timeout) else $error("no alarm after ack timeout");

  property p_invest_reset;
    @(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_INVEST && sys_reset_i && !other_init_i && !second_sel) |=> state_r == ST_IDLE;
  endproperty
  a_invest_reset: assert property (p_invest_reset) else $error("reset did not cancel");

  property p_inv_timeout;
    @(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_INVEST && inv_exp && !sys_reset_i) |=> notify_o && remote_o;
  endproperty
  a_inv_timeout: assert property (p_inv_timeout) else $error("no alarm after investigation");

  property p_second;
    @(posedge core_clk_i) disable iff (rst_i) (state_r == ST_INVEST && second_sel) |=> notify_o;
  endproperty
  a_second: assert property (p_second) else $error("second detector ignored");

  property p_other;
    @(posedge core_clk_i) disable iff (rst_i) other_init_i |=> notify_o && remote_o;
  endproperty
  a_other: assert property (p_other) else $error("other device did not alarm");

  property p_idle_quiet;
    @(posedge core_clk_i) disable iff (rst_i) state_r == ST_IDLE |-> !notify_o && sec_r == SEC_ZERO;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle not quiet");

  property p_sec_bound;
    @(posedge core_clk_i) disable iff (rst_i) state_r == ST_ACK |-> sec_r < ACK_LAST;
  endproperty
  a_sec_bound: assert property (p_sec_bound) else $error("ack window overran");

  // multi-step behaviours start from these named triggers
  sequence s_timely_ack;
    state_r == ST_ACK && ack_i && !other_init_i;
  endsequence

  sequence s_cancel;
    state_r == ST_INVEST && sys_reset_i && !other_init_i && !second_sel;
  endsequence

  property p_ack_starts;
    @(posedge core_clk_i) disable iff (rst_i) s_timely_ack |=> state_r == ST_INVEST && !notify_o;
  endproperty
  a_ack_starts: assert property (p_ack_starts) else $error("ack did not start investigation");

  property p_cancel_quiet;
    @(posedge core_clk_i) disable iff (rst_i)
      s_cancel |=> !notify_o && !remote_o && !annunciate_o && sec_r == SEC_ZERO;
  endproperty
  a_cancel_quiet: assert property (p_cancel_quiet) else $error("cancel left outputs active");

  property p_remote_follows;
    @(posedge core_clk_i) disable iff (rst_i) remote_o == notify_o;
  endproperty
  a_remote_follows: assert property (p_remote_follows) else $error("remote differs from notify");

  property p_alarm_latched;
    @(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_ALARM && !(sys_reset_i && !other_init_i && !any_sel)) |=> state_r == ST_ALARM && notify_o;
  endproperty
  a_alarm_latched: assert property (p_alarm_latched) else $error("alarm dropped");

  property p_idle_ack_refused;
    @(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_IDLE && !other_init_i && !any_sel) |=> state_r == ST_IDLE && !annunciate_o;
  endproperty
  a_idle_ack_refused: assert property (p_idle_ack_refused) else $error("idle left without input");

  property p_ack_reset_refused;
    @(posedge core_clk_i) disable iff (rst_i)
      (state_r == ST_ACK && !other_init_i && !ack_i && !ack_exp) |=> state_r == ST_ACK;
  endproperty
  a_ack_reset_refused: assert property (p_ack_reset_refused) else $error("ack window left early");

  property p_inv_bound;
    @(posedge core_clk_i) disable iff (rst_i) state_r == ST_INVEST |-> sec_r < INV_LAST;
  endproperty
  a_inv_bound: assert property (p_inv_bound) else $error("investigation overran");

  // the seconds pulse must never stretch, or windows would run short
  property p_tick_pulse;
    @(posedge core_clk_i) disable iff (rst_i) tick |=> !tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
endmodule

// File: bench/appliance_model.sv
// notification appliance model at the far side of the sequencer
`timescale 1ns/1ps
module appliance_model (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // alarm paths from the sequencer
  input  wire logic notify_i,
  input  wire logic remote_i,
  // appliance state
  output logic      sounding_o
);
  // sounds only when both paths agree, so a lone path shows as silence
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) sounding_o <= 1'b0;
    else sounding_o <= notify_i & remote_i;
  end
endmodule

// File: bench/tb.sv
// self-checking bench for the delayed-alarm sequencer
`timescale 1ns/1ps
module tb;
  import alarm_seq_pkg::*;
  // short tick keeps the run small; the window waits and the watchdog derive from these
  localparam int TK = 4, AK = 3, IV = 5;
  logic core_clk_i = 0, rst_i = 1, other_init_i = 0, ack_i = 0, sys_reset_i = 0;
  logic [7:0] sel_det_i = 8'h00;
  logic annunciate_o, notify_o, remote_o, sounding;
  seq_state_type state_o;
  int n_fail = 0, num_checks = 0, b;
  always #5 core_clk_i = ~core_clk_i;
  positive_alarm_sequencer #(.TICK_CYCLES(TK), .ACK_S(AK), .INVEST_S(IV)) dut (.core_clk_i, .rst_i,
    .sel_det_i, .other_init_i, .ack_i, .sys_reset_i, .annunciate_o, .notify_o, .remote_o, .state_o);
  appliance_model app (.core_clk_i, .rst_i, .notify_i(notify_o), .remote_i(remote_o), .sounding_o(sounding));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(string nm, logic [1:0] e, logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // cycles in a window of s seconds at the short bench tick
  function automatic int lapse(int s);
    return s * TK;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // bounded wait; the window end may slip by one tick alignment
  task automatic wait_alarm();
    for (int c = 0; c < TK + 6 && notify_o !== 1'b1; c++) begin
      cyc(1);
      #2;
    end
  endtask
  task automatic restart();
    @(posedge core_clk_i);
    rst_i <= 1;
    sel_det_i <= 8'h00;
    other_init_i <= 0;
    @(posedge core_clk_i);
    rst_i <= 0;
  endtask
  task automatic start(int d);
    @(posedge core_clk_i);
    sel_det_i <= 8'h01 << d;
    cyc(2);
    #2;
    chk("annunciate", 1, annunciate_o);
    chk("ack state", ST_ACK, state_o);
  endtask
  task automatic acknowledge();
    @(posedge core_clk_i);
    ack_i <= 1;
    @(posedge core_clk_i);
    ack_i <= 0;
    cyc(1);
    #2;
    chk("invest state", ST_INVEST, state_o);
  endtask
  task automatic op_reset();
    @(posedge core_clk_i);
    sel_det_i <= 8'h00;
    sys_reset_i <= 1;
    @(posedge core_clk_i);
    sys_reset_i <= 0;
    cyc(2);
    #2;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    b = $urandom(16252);
    cyc(3);
    rst_i <= 0;
    start(0);
    // a reset inside the acknowledge window must be refused
    @(posedge core_clk_i);
    sys_reset_i <= 1;
    @(posedge core_clk_i);
    sys_reset_i <= 0;
    cyc(1);
    #2;
    chk("reset refused", ST_ACK, state_o);
    cyc(lapse(AK) - 4);
    #2;
    chk("notify early", 0, notify_o);
    wait_alarm();
    chk("notify lapse", 1, notify_o);
    chk("remote lapse", 1, remote_o);
    cyc(1);
    #2;
    chk("appliance", 1, sounding);
    op_reset();
    chk("cleared", ST_IDLE, state_o);
    // acknowledge with no sequence open is ignored
    @(posedge core_clk_i);
    ack_i <= 1;
    @(posedge core_clk_i);
    ack_i <= 0;
    cyc(1);
    #2;
    chk("ack refused", ST_IDLE, state_o);
    for (int m = 0; m < 8; m++) begin
      b = $urandom_range(7);
      restart();
      if (m % 4 == 3) begin
        @(posedge core_clk_i);
        other_init_i <= 1;
        cyc(2);
        #2;
        chk("other init", 1, notify_o & remote_o);
        // reset while the device is still active must not clear the alarm
        @(posedge core_clk_i);
        sys_reset_i <= 1;
        @(posedge core_clk_i);
        sys_reset_i <= 0;
        cyc(1);
        #2;
        chk("alarm latched", ST_ALARM, state_o);
      end else begin
        start(b);
        acknowledge();
        if (m % 4 == 0) begin
          op_reset();
          cyc(lapse(IV) + 4);
          #2;
          chk("cancel state", ST_IDLE, state_o);
          chk("cancel annunciate", 0, annunciate_o);
          chk("cancel notify", 0, notify_o | remote_o);
        end else if (m % 4 == 1) begin
          cyc(lapse(IV) - 1);
          #2;
          chk("invest early", 0, notify_o);
          wait_alarm();
          chk("invest expiry", 1, notify_o & remote_o);
        end else begin
          @(posedge core_clk_i);
          sel_det_i <= sel_det_i | (8'h01 << ((b + 1 + $urandom_range(6)) % 8));
          cyc(2);
          #2;
          chk("second det", 1, notify_o & remote_o);
        end
      end
    end
    close_out();
  end
  // watchdog well past the longest expected run
  initial begin
    repeat (40 * lapse(AK + IV)) @(posedge core_clk_i);
    n_fail++;
    close_out();
  end
endmodule
